// File: tpg_map.vh
`ifndef TPG_MAP_VH
`define TPG_MAP_VH

// number of generator blocks and outputs per block
`define TPG_NGEN      3
`define TPG_OUTS      2

// counter events, bit index in the event vector
`define TPG_EV_ZERO   0
`define TPG_EV_LOAD   1
`define TPG_EV_AUP    2
`define TPG_EV_ADN    3
`define TPG_EV_BUP    4
`define TPG_EV_BDN    5
`define TPG_EV_N      6

// output action codes, two bits per event
`define TPG_ACT_W     2
`define TPG_ACT_NONE  2'h0
`define TPG_ACT_TOG   2'h1
`define TPG_ACT_LOW   2'h2
`define TPG_ACT_HIGH  2'h3

// reset values and direction codes
`define TPG_RST_BIT   1'b0
`define TPG_DIR_DOWN  1'b0
`define TPG_DIR_UP    1'b1

`endif

// File: tpg_pwm.v
// Summary of operation
// - three generators: counter, comparators, signals, deadband
// - down mode counts load to zero, reloads
// - up/down mode counts zero to load, back
// - direction plus one-cycle zero and load pulses
// - match pulses, direction qualified in up/down
// - match above load never fires
// - four events down, six up/down
// - matches ignored when coinciding zero or load
// - coincident matches: A to first, B second
// - per event action: none, toggle, low, high
// - deadband: delayed rise, inverted delayed complement
// - interrupt on any selected counter event
// - converter trigger from separate event selection
// - interrupt and trigger use raw events
// - global reset clears selected counters together
// - immediate update takes effect at zero
// - synchronous update waits global strobe, then zero
// - update mode chosen per generator
// - per-output fault forcing inactive, fault interrupt
// - stall: keep running or halt at zero
// - enable mask and optional inversion per pin
`timescale 1ns/1ps
`default_nettype none
`include "tpg_map.vh"

module tpg_pwm #(
  parameter CW = 16,
  parameter DW = 8
) (
  input  wire                              clk_sys,
  input  wire                              resetn,
  input  wire [`TPG_NGEN-1:0]              gen_run,
  input  wire [`TPG_NGEN-1:0]              gen_updown,
  input  wire [`TPG_NGEN-1:0]              gen_sync_update,
  input  wire [`TPG_NGEN-1:0]              gen_stall_halt,
  input  wire [`TPG_NGEN-1:0]              gen_deadband_en,
  input  wire [`TPG_NGEN-1:0]              counter_reset,
  input  wire                              global_update,
  input  wire                              debug_stall,
  input  wire [`TPG_NGEN*CW-1:0]           load_value,
  input  wire [`TPG_NGEN*CW-1:0]           match_a_value,
  input  wire [`TPG_NGEN*CW-1:0]           match_b_value,
  input  wire [`TPG_NGEN*`TPG_EV_N*2-1:0]  first_action,
  input  wire [`TPG_NGEN*`TPG_EV_N*2-1:0]  second_action,
  input  wire [`TPG_NGEN*DW-1:0]           rise_delay,
  input  wire [`TPG_NGEN*DW-1:0]           fall_delay,
  input  wire [`TPG_NGEN*`TPG_EV_N-1:0]    irq_select,
  input  wire [`TPG_NGEN*`TPG_EV_N-1:0]    trigger_select,
  input  wire                              fault_in,
  input  wire [`TPG_NGEN*2-1:0]            fault_enable,
  input  wire                              fault_irq_enable,
  input  wire [`TPG_NGEN*2-1:0]            out_enable,
  input  wire [`TPG_NGEN*2-1:0]            out_invert,
  output reg  [`TPG_NGEN*2-1:0]            pwm_pin,
  output reg  [`TPG_NGEN*2-1:0]            pwm_pin_oe,
  output reg  [`TPG_NGEN-1:0]              gen_irq,
  output reg  [`TPG_NGEN-1:0]              adc_trigger,
  output reg                               fault_irq,
  output wire [`TPG_NGEN*CW-1:0]           count_value,
  output wire [`TPG_NGEN-1:0]              count_dir
);

  localparam NG = `TPG_NGEN;
  localparam NO = NG * `TPG_OUTS;
  localparam NE = `TPG_EV_N;
  localparam AW = `TPG_EV_N * `TPG_ACT_W;
  localparam [CW-1:0] CNT_ZERO = {CW{1'b0}};
  localparam [CW-1:0] CNT_ONE  = {{(CW-1){1'b0}}, 1'b1};
  localparam [DW-1:0] DB_ZERO  = {DW{1'b0}};
  localparam [DW-1:0] DB_ONE   = {{(DW-1){1'b0}}, 1'b1};
  // event groups of each comparator, for coincidence steering
  localparam [NE-1:0] EV_ONE   = {{(NE-1){1'b0}}, 1'b1};
  localparam [NE-1:0] A_EVENTS = (EV_ONE << `TPG_EV_AUP) | (EV_ONE << `TPG_EV_ADN);
  localparam [NE-1:0] B_EVENTS = (EV_ONE << `TPG_EV_BUP) | (EV_ONE << `TPG_EV_BDN);

  // one action applied to the current output level
  function act_apply;
    input       cur;
    input [1:0] act;
    begin
      case (act)
        `TPG_ACT_NONE: act_apply = cur;
        `TPG_ACT_TOG:  act_apply = ~cur;
        `TPG_ACT_LOW:  act_apply = 1'b0;
        `TPG_ACT_HIGH: act_apply = 1'b1;
        default:       act_apply = cur;
      endcase
    end
  endfunction

  // all active events applied in index order
  function act_chain;
    input          cur;
    input [NE-1:0] ev;
    input [AW-1:0] acts;
    integer        e;
    reg            v;
    begin
      v = cur;
      for (e = 0; e < NE; e = e + 1) begin
        if (ev[e])
          v = act_apply(v, acts[e*`TPG_ACT_W +: `TPG_ACT_W]);
      end
      act_chain = v;
    end
  endfunction

  wire [NO-1:0] gen_sig;
  wire [NG-1:0] irq_hit;
  wire [NG-1:0] trig_hit;
  wire [NO-1:0] fault_mask;
  wire [NO-1:0] next_pin;

  genvar g;
  generate
    for (g = 0; g < NG; g = g + 1) begin : gen_blk
      reg  [CW-1:0] cnt;
      reg           dir;
      reg  [CW-1:0] hold_load;
      reg  [CW-1:0] hold_a;
      reg  [CW-1:0] hold_b;
      reg  [CW-1:0] use_load;
      reg  [CW-1:0] use_a;
      reg  [CW-1:0] use_b;
      reg           first_generator_output;
      reg           second_generator_output;
      reg  [DW-1:0] rise_cnt;
      reg  [DW-1:0] fall_cnt;
      reg           db_first;
      reg           db_second;
      wire          at_zero;
      wire          at_load;
      wire          step;
      wire          hit_a;
      wire          hit_b;
      wire          both_hit;
      wire [NE-1:0] ev;
      wire [NE-1:0] ev_first;
      wire [NE-1:0] ev_second;
      wire          rise_done;
      wire          fall_done;
      wire [CW-1:0] load_in;
      wire [CW-1:0] match_a_in;
      wire [CW-1:0] match_b_in;
      wire [AW-1:0] acts_first;
      wire [AW-1:0] acts_second;
      wire [DW-1:0] rise_len;
      wire [DW-1:0] fall_len;
      wire [NE-1:0] irq_mask;
      wire [NE-1:0] trig_mask;
      wire [NE-1:0] irq_ev;
      wire [NE-1:0] trig_ev;

      // this generator's slice of the packed inputs
      assign load_in     = load_value[g*CW +: CW];
      assign match_a_in  = match_a_value[g*CW +: CW];
      assign match_b_in  = match_b_value[g*CW +: CW];
      assign acts_first  = first_action[g*AW +: AW];
      assign acts_second = second_action[g*AW +: AW];
      assign rise_len    = rise_delay[g*DW +: DW];
      assign fall_len    = fall_delay[g*DW +: DW];
      assign irq_mask    = irq_select[g*NE +: NE];
      assign trig_mask   = trigger_select[g*NE +: NE];

      // counter state decode
      assign at_zero = (cnt == CNT_ZERO);
      assign at_load = (cnt == use_load);

      // counter advances unless halted at zero under stall
      assign step = gen_run[g] & ~(debug_stall & gen_stall_halt[g] & at_zero);

      // comparator hits, suppressed above load and on zero or load
      assign hit_a = (cnt == use_a) & (use_a <= use_load)
                     & ~at_zero & ~at_load;
      assign hit_b = (cnt == use_b) & (use_b <= use_load)
                     & ~at_zero & ~at_load;
      assign both_hit = hit_a & hit_b;

      // raw one-cycle events
      assign ev[`TPG_EV_ZERO] = step & at_zero;
      assign ev[`TPG_EV_LOAD] = step & at_load;
      assign ev[`TPG_EV_AUP]  = step & hit_a & dir;
      assign ev[`TPG_EV_ADN]  = step & hit_a & ~dir;
      assign ev[`TPG_EV_BUP]  = step & hit_b & dir;
      assign ev[`TPG_EV_BDN]  = step & hit_b & ~dir;

      // coincident matches steer A to first and B to second
      assign ev_first  = both_hit ? (ev & ~B_EVENTS) : ev;
      assign ev_second = both_hit ? (ev & ~A_EVENTS) : ev;

      // new values staged per update mode
      always @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
          hold_load <= CNT_ZERO;
          hold_a    <= CNT_ZERO;
          hold_b    <= CNT_ZERO;
        end else if (!gen_sync_update[g] || global_update) begin
          hold_load <= load_in;
          hold_a    <= match_a_in;
          hold_b    <= match_b_in;
        end
      end

      // staged values take effect at counter zero
      always @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
          use_load <= CNT_ZERO;
          use_a    <= CNT_ZERO;
          use_b    <= CNT_ZERO;
        end else if (ev[`TPG_EV_ZERO] || counter_reset[g]) begin
          use_load <= hold_load;
          use_a    <= hold_a;
          use_b    <= hold_b;
        end
      end

      // counter, one step per clock
      always @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
          cnt <= CNT_ZERO;
          dir <= `TPG_DIR_DOWN;
        end else if (counter_reset[g]) begin
          cnt <= CNT_ZERO;
          dir <= `TPG_DIR_DOWN;
        end else if (step) begin
          if (!gen_updown[g]) begin
            dir <= `TPG_DIR_DOWN;
            if (at_zero)
              cnt <= hold_load;
            else
              cnt <= cnt - CNT_ONE;
          end else if (dir == `TPG_DIR_UP) begin
            if (at_load) begin
              dir <= `TPG_DIR_DOWN;
              if (!at_zero)
                cnt <= cnt - CNT_ONE;
            end else begin
              cnt <= cnt + CNT_ONE;
            end
          end else begin
            if (at_zero) begin
              dir <= `TPG_DIR_UP;
              if (!at_load)
                cnt <= cnt + CNT_ONE;
            end else begin
              cnt <= cnt - CNT_ONE;
            end
          end
        end
      end

      // signal generator, both outputs
      always @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
          first_generator_output  <= `TPG_RST_BIT;
          second_generator_output <= `TPG_RST_BIT;
        end else begin
          first_generator_output  <= act_chain(first_generator_output, ev_first,
                                               acts_first);
          second_generator_output <= act_chain(second_generator_output, ev_second,
                                               acts_second);
        end
      end

      // dead-band delay counters
      assign rise_done = (rise_cnt >= rise_len);
      assign fall_done = (fall_cnt >= fall_len);

      always @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
          rise_cnt <= DB_ZERO;
          fall_cnt <= DB_ZERO;
        end else begin
          if (!first_generator_output)
            rise_cnt <= DB_ZERO;
          else if (!rise_done)
            rise_cnt <= rise_cnt + DB_ONE;
          if (first_generator_output)
            fall_cnt <= DB_ZERO;
          else if (!fall_done)
            fall_cnt <= fall_cnt + DB_ONE;
        end
      end

      // dead-band stage or pass-through
      always @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
          db_first  <= `TPG_RST_BIT;
          db_second <= `TPG_RST_BIT;
        end else if (gen_deadband_en[g]) begin
          db_first  <= first_generator_output & rise_done;
          db_second <= ~first_generator_output & fall_done;
        end else begin
          db_first  <= first_generator_output;
          db_second <= second_generator_output;
        end
      end

      assign gen_sig[`TPG_OUTS*g]     = db_first;
      assign gen_sig[`TPG_OUTS*g + 1] = db_second;

      // event selectors from raw events
      assign irq_ev      = ev & irq_mask;
      assign trig_ev     = ev & trig_mask;
      assign irq_hit[g]  = |irq_ev;
      assign trig_hit[g] = |trig_ev;

      assign count_value[g*CW +: CW] = cnt;
      assign count_dir[g]            = dir;
    end
  endgenerate

  // event interrupt and trigger pulses, one cycle each; fault interrupt follows the fault input
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      gen_irq     <= {NG{1'b0}};
      adc_trigger <= {NG{1'b0}};
      fault_irq   <= `TPG_RST_BIT;
    end else begin
      gen_irq     <= irq_hit;
      adc_trigger <= trig_hit;
      fault_irq   <= fault_in & fault_irq_enable;
    end
  end

  // fault forcing ahead of the pin inversion
  assign fault_mask = fault_enable & {NO{fault_in}};
  assign next_pin   = out_enable & ((gen_sig & ~fault_mask) ^ out_invert);

  // output control: fault force, inversion, enable mask
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      pwm_pin    <= {NO{1'b0}};
      pwm_pin_oe <= {NO{1'b0}};
    end else begin
      pwm_pin    <= next_pin;
      pwm_pin_oe <= out_enable;
    end
  end

endmodule // tpg_pwm
`default_nettype wire

// File: tpg_drv_model.sv
`timescale 1ns/1ps
`default_nettype none
module tpg_drv_model (
  input  wire logic       clk_sys,
  input  wire logic [5:0] pwm_pin,
  input  wire logic [5:0] pwm_pin_oe,
  input  wire logic [2:0] adc_trigger,
  output wire logic [5:0] gate,
  output var  logic [7:0] trig_count
);
  // released pins fall to the driver pull-down
  assign gate = pwm_pin & pwm_pin_oe;
  // converter counts trigger pulses
  initial trig_count = 8'h00;
  always @(posedge clk_sys) trig_count <= trig_count + {7'h00, |adc_trigger};
endmodule // tpg_drv_model
`default_nettype wire

// File: tpg_pwm_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module tpg_pwm_asserts #(parameter CW = 16) (
  input wire logic            clk_sys,
  input wire logic            resetn,
  input wire logic [2:0]      gen_run,
  input wire logic [2:0]      gen_updown,
  input wire logic [2:0]      gen_deadband_en,
  input wire logic [2:0]      counter_reset,
  input wire logic            debug_stall,
  input wire logic [17:0]     irq_select,
  input wire logic [17:0]     trigger_select,
  input wire logic            fault_in,
  input wire logic [5:0]      fault_enable,
  input wire logic            fault_irq_enable,
  input wire logic [5:0]      out_enable,
  input wire logic [5:0]      out_invert,
  input wire logic [5:0]      pwm_pin,
  input wire logic [5:0]      pwm_pin_oe,
  input wire logic [2:0]      gen_irq,
  input wire logic [2:0]      adc_trigger,
  input wire logic            fault_irq,
  input wire logic [3*CW-1:0] count_value,
  input wire logic [2:0]      count_dir
);
  // generator zero helpers
  wire [CW-1:0] c0 = count_value[CW-1:0];
  wire          run0 = gen_run[0] && !debug_stall;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  // counter, events and pin conditioning
  property p_down; run0 && !gen_updown[0] && !counter_reset[0] && c0 != 0 |=> c0 == $past(c0) - 1'b1; endproperty
  a_down: assert property (p_down) else $error("down step wrong");
  property p_dir; gen_run[0] && !gen_updown[0] |=> !count_dir[0]; endproperty
  a_dir: assert property (p_dir) else $error("dir high in down mode");
  property p_crst; counter_reset[0] |=> c0 == 0 && !count_dir[0]; endproperty
  a_crst: assert property (p_crst) else $error("counter not cleared");
  property p_oe; $past(resetn) |-> pwm_pin_oe == $past(out_enable); endproperty
  a_oe: assert property (p_oe) else $error("oe not following enable");
  property p_firq; $past(resetn) |-> fault_irq == $past(fault_in && fault_irq_enable); endproperty
  a_firq: assert property (p_firq) else $error("fault irq wrong");
  property p_irqz; run0 && irq_select[0] && c0 == 0 |=> gen_irq[0]; endproperty
  a_irqz: assert property (p_irqz) else $error("zero irq missing");
  property p_trgl;
    run0 && !counter_reset[0] && !gen_updown[0] && trigger_select[1] && c0 == 0 ##1 run0
      |=> adc_trigger[0];
  endproperty
  a_trgl: assert property (p_trgl) else $error("load trigger missing");
  property p_fpin; (fault_in && fault_enable[0] && !out_invert[0])[*3] |-> !pwm_pin[0]; endproperty
  a_fpin: assert property (p_fpin) else $error("fault not forcing pin");
  property p_off; (!out_enable[0])[*3] |-> !pwm_pin[0] && !pwm_pin_oe[0]; endproperty
  a_off: assert property (p_off) else $error("disabled pin active");
  property p_dbx;
    (gen_deadband_en[0] && out_invert[1:0] == 2'h0)[*3] |-> !(pwm_pin[0] && pwm_pin[1]);
  endproperty
  a_dbx: assert property (p_dbx) else $error("deadband pair overlap");
  c_irq: cover property (gen_irq[0]);
  c_fault: cover property (fault_irq);
  c_updn: cover property (count_dir[1]);
endmodule // tpg_pwm_asserts
bind tpg_pwm tpg_pwm_asserts #(.CW(CW)) u_chk (.*);
`default_nettype wire

// File: tpg_pwm_bench.sv
`timescale 1ns/1ps
`default_nettype none
module tpg_pwm_bench;
  logic clk_sys = 1'b0, resetn = 1'b0, global_update = 1'b0, debug_stall = 1'b0;
  logic fault_in = 1'b0, fault_irq_enable = 1'b0, fault_irq;
  logic [2:0] gen_run = 3'h0, gen_updown = 3'h0, gen_sync_update = 3'h0, gen_stall_halt = 3'h0;
  logic [2:0] gen_deadband_en = 3'h0, counter_reset = 3'h0, gen_irq, adc_trigger, count_dir;
  logic [47:0] load_value = 48'h0, match_a_value = 48'h0, match_b_value = 48'h0, count_value;
  logic [35:0] first_action = 36'h0, second_action = 36'h0;
  logic [23:0] rise_delay = 24'h0, fall_delay = 24'h0;
  logic [17:0] irq_select = 18'h0, trigger_select = 18'h0;
  logic [5:0] fault_enable = 6'h0, out_enable = 6'h0, out_invert = 6'h0, pwm_pin, pwm_pin_oe, gate;
  logic [7:0] trig_count;
  int failures = 0, compares = 0;
  always #5 clk_sys = ~clk_sys;
  tpg_pwm i_dut (.*);
  tpg_drv_model i_drv (.*);
  // compare and closing report
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] s);
    compares++;
    if (s !== e) begin
      failures++;
      $display("mismatch %s expected %0h seen %0h", n, e, s);
    end
  endtask
  task automatic results;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // highest count of one generator over twelve cycles
  task automatic peak(input int g, input logic [15:0] e);
    logic [15:0] m;
    m = 16'h0;
    repeat (12) begin
      @(posedge clk_sys);
      #1;
      if (count_value[g*16+:16] > m) m = count_value[g*16+:16];
    end
    chk("peak", e, m);
  endtask
  // new match, fault and inversion, then high cycles of the first pin
  task automatic wv(input logic [15:0] m, input logic f, input logic v, input int e);
    int n;
    @(posedge clk_sys);
    match_a_value[15:0] <= m;
    fault_in <= f;
    out_invert[0] <= v;
    n = 0;
    repeat (10) @(posedge clk_sys);
    repeat (8) begin
      @(posedge clk_sys);
      #1;
      n += gate[0];
    end
    chk("pin_high", e, n[15:0]);
  endtask
  task automatic t_rst;
    #1;
    chk("pins", 16'h0, {pwm_pin, pwm_pin_oe});
    chk("count", 16'h0, count_value[15:0] | count_value[31:16] | count_value[47:32]);
  endtask
  task automatic t_down;
    @(posedge clk_sys);
    load_value[15:0] <= 16'h0003;
    irq_select[0] <= 1'b1;
    trigger_select[1] <= 1'b1;
    @(posedge clk_sys);
    counter_reset[0] <= 1'b1; // make the new load active first
    @(posedge clk_sys);
    counter_reset[0] <= 1'b0;
    gen_run[0] <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      @(posedge clk_sys);
      #1;
      chk("cnt_down", 16'h3 - i, count_value[15:0]);
      chk("irq_trig", {i == 0, i == 1}, {gen_irq[0], adc_trigger[0]});
    end
    chk("trig_count", 8'h01, trig_count);
  endtask
  task automatic t_updn;
    int n;
    @(posedge clk_sys);
    load_value[31:16] <= 16'h0003;
    gen_updown[1] <= 1'b1;
    @(posedge clk_sys);
    gen_run[1] <= 1'b1;
    for (n = 0; n < 20 && count_value[31:16] !== 16'h0001; n++) begin
      @(posedge clk_sys);
      #1;
    end
    if (n == 20) begin
      failures++;
      results;
    end
    for (int i = 0; i < 6; i++) begin
      @(posedge clk_sys);
      #1;
      chk("cnt_updn", (i < 2) ? i + 2 : (i < 5) ? 4 - i : 1, count_value[31:16]);
      if (i == 0 || i == 2) chk("dir", i == 0, count_dir[1]);
    end
  endtask
  task automatic t_wave;
    @(posedge clk_sys);
    first_action[1:0] <= 2'h3;
    first_action[7:6] <= 2'h2;
    fault_enable[0] <= 1'b1;
    fault_irq_enable <= 1'b1;
    out_enable[0] <= 1'b1;
    wv(16'h1, 1'b0, 1'b0, 6);
    wv(16'h5, 1'b0, 1'b0, 8);
    wv(16'h0, 1'b0, 1'b0, 8);
    wv(16'h1, 1'b1, 1'b0, 0);
    chk("fault_irq", 1'b1, fault_irq);
    wv(16'h1, 1'b1, 1'b1, 8);
    wv(16'h1, 1'b0, 1'b1, 2);
    @(posedge clk_sys);
    match_b_value[15:0] <= 16'h0001;
    first_action[11:10] <= 2'h1;
    wv(16'h1, 1'b0, 1'b0, 6);
  endtask
  // dead-band pair from the first output, events stay raw
  task automatic t_db;
    int n0, n1, n2;
    @(posedge clk_sys);
    gen_deadband_en[0] <= 1'b1;
    rise_delay[7:0] <= 8'h01;
    out_enable[1] <= 1'b1;
    n0 = 0;
    n1 = 0;
    n2 = 0;
    repeat (10) @(posedge clk_sys);
    repeat (8) begin
      @(posedge clk_sys);
      #1;
      n0 += gate[0];
      n1 += gate[1];
      n2 += gen_irq[0];
    end
    chk("db_first", 16'h4, n0[15:0]);
    chk("db_second", 16'h2, n1[15:0]);
    chk("db_irq", 16'h2, n2[15:0]);
  endtask
  task automatic t_stall;
    @(posedge clk_sys);
    gen_stall_halt[0] <= 1'b1;
    debug_stall <= 1'b1;
    repeat (8) @(posedge clk_sys);
    peak(0, 16'h0);
    chk("stall_irq", 1'b0, gen_irq[0]);
    peak(1, 16'h3);
    @(posedge clk_sys);
    debug_stall <= 1'b0;
  endtask
  task automatic t_sync;
    @(posedge clk_sys);
    gen_sync_update[2] <= 1'b1;
    load_value[47:32] <= 16'h0005;
    gen_run[2] <= 1'b1;
    peak(2, 16'h0);
    @(posedge clk_sys);
    global_update <= 1'b1;
    @(posedge clk_sys);
    global_update <= 1'b0;
    peak(2, 16'h5);
    @(posedge clk_sys);
    counter_reset <= 3'h5;
    @(posedge clk_sys);
    counter_reset <= 3'h0;
    #1;
    chk("sync_rst", 16'h0, count_value[15:0] | count_value[47:32]);
  endtask
  // main sequence
  initial begin
    repeat (20) @(posedge clk_sys);
    resetn <= 1'b1;
    t_rst;
    t_down;
    t_updn;
    t_wave;
    t_db;
    t_stall;
    t_sync;
    results;
  end
endmodule // tpg_pwm_bench
`default_nettype wire
